// ### logic/iss_pkg.sv
// Shared constants for the serial startup and warm reset sequencer
package iss_pkg;
	localparam int CLK_HZ                   = 20000000;
	localparam int STARTUP_DELAY_MS         = 15;
	localparam int STARTUP_DELAY_LONG_MS    = 20;
	localparam int RESET_DETECT_MIN_TIME_US = 10;
	localparam int RESET_RELEASE_MAX_TIME_US = 2500;
	localparam int RESET_LOW_HOLD_US        = 20;
	// Detect minimum rounds up, all other times round down
	localparam int STARTUP_DELAY_CYC      = (STARTUP_DELAY_MS * (CLK_HZ / 1000));
	localparam int STARTUP_DELAY_LONG_CYC = (STARTUP_DELAY_LONG_MS * (CLK_HZ / 1000));
	localparam int RESET_DETECT_MIN_CYC   =
		(RESET_DETECT_MIN_TIME_US * CLK_HZ + 999999) / 1000000;
	localparam int RESET_RELEASE_MAX_CYC  = RESET_RELEASE_MAX_TIME_US * (CLK_HZ / 1000000);
	localparam int RESET_LOW_HOLD_CYC     = RESET_LOW_HOLD_US * (CLK_HZ / 1000000);
	localparam int CNT_W                  = 20;
endpackage : iss_pkg

// ### logic/iss_link_if.sv
// Interface joining the host and device ends of the reset and serial lines
`timescale 1ns/1ps
interface iss_link_if;
	logic rst_pin_n;
	logic scl_o;
	logic scl_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	// Open-drain wired-AND with pull-up
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
	modport host (output rst_pin_n, output scl_o, output scl_oe, output sda_host_o,
		output sda_host_oe, input scl, input sda);
	modport dev (input rst_pin_n, input scl, input sda, output sda_dev_o,
		output sda_dev_oe);
endinterface : iss_link_if

// ### logic/iss_host.sv
// Host end: drives reset pin, serial lines and enforces startup waits
`timescale 1ns/1ps
module iss_host
	import iss_pkg::*;
#(
	parameter int STARTUP_CYC      = STARTUP_DELAY_LONG_CYC,
	parameter int RESET_HOLD_CYC   = RESET_LOW_HOLD_CYC,
	parameter int RESET_LIMIT_CYC  = RESET_RELEASE_MAX_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	iss_link_if.host  link,
	input  wire logic warm_reset_req,
	input  wire logic bus_busy,
	input  wire logic scl_drive_low,
	input  wire logic sda_drive_low,
	output logic      bus_ready,
	output logic      reset_active
);
	typedef enum logic [3:0] {
		H_POWER = 4'h1,
		H_READY = 4'h2,
		H_LOW   = 4'h4,
		H_WAIT  = 4'h8
	} iss_hstate_t;

	typedef struct packed {
		iss_hstate_t      st;
		logic [CNT_W-1:0] cnt;
		logic             rst_pin_n;
		logic             scl_low;
		logic             sda_low;
		logic             ready;
		logic             active;
	} iss_hreg_t;

	iss_hreg_t s_r;
	iss_hreg_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_low = 1'b0;
		s_nxt.sda_low = 1'b0;
		case (s_r.st)
			H_POWER: begin
				// Lines stay released high while the device powers up
				s_nxt.cnt = s_r.cnt + 1'b1;
				if (s_r.cnt >= CNT_W'(STARTUP_CYC - 1)) begin
					s_nxt.st = H_READY;
					s_nxt.ready = 1'b1;
					s_nxt.cnt = '0;
				end
			end
			H_READY: begin
				s_nxt.scl_low = scl_drive_low;
				s_nxt.sda_low = sda_drive_low;
				// Reset waits until traffic ends and the host's own pulls on both lines are released
				if (warm_reset_req && !bus_busy && !scl_drive_low && !sda_drive_low
					&& !s_r.scl_low && !s_r.sda_low) begin
					s_nxt.st = H_LOW;
					s_nxt.rst_pin_n = 1'b0;
					s_nxt.active = 1'b1;
					s_nxt.ready = 1'b0;
					s_nxt.scl_low = 1'b0;
					s_nxt.sda_low = 1'b0;
				end
			end
			H_LOW: begin
				s_nxt.cnt = s_r.cnt + 1'b1;
				// Hold long enough to be seen, release before the limit
				if (s_r.cnt >= CNT_W'(RESET_HOLD_CYC - 1)
					|| s_r.cnt >= CNT_W'(RESET_LIMIT_CYC - 1)) begin
					s_nxt.st = H_WAIT;
					s_nxt.rst_pin_n = 1'b1;
					s_nxt.active = 1'b0;
					s_nxt.cnt = '0;
				end
			end
			H_WAIT: begin
				s_nxt.cnt = s_r.cnt + 1'b1;
				// Wait covers the stretched startup after a pending write
				if (s_r.cnt >= CNT_W'(STARTUP_CYC - 1)) begin
					s_nxt.st = H_READY;
					s_nxt.ready = 1'b1;
					s_nxt.cnt = '0;
				end
			end
			default: begin
				s_nxt.st = H_POWER;
				s_nxt.cnt = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '{st: H_POWER, cnt: '0, rst_pin_n: 1'b1, scl_low: 1'b0,
				sda_low: 1'b0, ready: 1'b0, active: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.rst_pin_n   = s_r.rst_pin_n;
	assign link.scl_o       = 1'b0;
	assign link.scl_oe      = s_r.scl_low;
	assign link.sda_host_o  = 1'b0;
	assign link.sda_host_oe = s_r.sda_low;
	assign bus_ready        = s_r.ready;
	// Own flop rather than an inverter so the output leaves a register directly
	assign reset_active     = s_r.active;
endmodule : iss_host

// ### logic/iss_dev.sv
// Device end: detects warm reset and gates the serial interface until startup
`timescale 1ns/1ps
module iss_dev
	import iss_pkg::*;
#(
	parameter int STARTUP_CYC      = STARTUP_DELAY_CYC,
	parameter int STARTUP_LONG_CYC = STARTUP_DELAY_LONG_CYC,
	parameter int DETECT_CYC       = RESET_DETECT_MIN_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	iss_link_if.dev   link,
	input  wire logic nvm_write_pending,
	input  wire logic sda_ack_low,
	output logic      bus_enable,
	output logic      warm_reset_seen,
	output logic      scl_sync,
	output logic      sda_sync
);
	typedef enum logic [2:0] {
		D_START = 3'h1,
		D_RUN   = 3'h2,
		D_RESET = 3'h4
	} iss_dstate_t;

	typedef struct packed {
		iss_dstate_t      st;
		logic [CNT_W-1:0] cnt;
		logic [2:0]       rst_sy;
		logic [2:0]       scl_sy;
		logic [2:0]       sda_sy;
		logic             rst_q;
		logic             scl_q;
		logic             sda_q;
		logic             long_start;
		logic             en;
		logic             seen;
		logic             drive;
	} iss_dreg_t;

	iss_dreg_t s_r;
	iss_dreg_t s_nxt;

	// A pin level counts once the second and third stages agree
	function automatic logic iss_filt(input logic [2:0] sy, input logic prev);
		iss_filt = (sy[1] == sy[2]) ? sy[2] : prev;
	endfunction : iss_filt

	always_comb begin
		s_nxt = s_r;
		s_nxt.rst_sy = {s_r.rst_sy[1:0], link.rst_pin_n};
		s_nxt.scl_sy = {s_r.scl_sy[1:0], link.scl};
		s_nxt.sda_sy = {s_r.sda_sy[1:0], link.sda};
		s_nxt.rst_q = iss_filt(s_r.rst_sy, s_r.rst_q);
		s_nxt.scl_q = iss_filt(s_r.scl_sy, s_r.scl_q);
		s_nxt.sda_q = iss_filt(s_r.sda_sy, s_r.sda_q);
		s_nxt.seen = 1'b0;
		case (s_r.st)
			D_START: begin
				if (!s_r.rst_q) begin
					s_nxt.st = D_RESET;
					s_nxt.cnt = '0;
				end else begin
					s_nxt.cnt = s_r.cnt + 1'b1;
					// Stay quiet for the startup delay, longer after a write
					if ((!s_r.long_start && s_r.cnt >= CNT_W'(STARTUP_CYC - 1))
						|| s_r.cnt >= CNT_W'(STARTUP_LONG_CYC - 1)) begin
						s_nxt.st = D_RUN;
						s_nxt.en = 1'b1;
						s_nxt.long_start = 1'b0;
					end
				end
			end
			D_RUN: begin
				if (!s_r.rst_q) begin
					s_nxt.st = D_RESET;
					s_nxt.en = 1'b0;
					s_nxt.cnt = '0;
				end
			end
			D_RESET: begin
				// Pulse too short to count raises no seen flag but still reruns startup; long pulse restarts
				if (s_r.cnt != CNT_W'(DETECT_CYC))
					s_nxt.cnt = s_r.cnt + 1'b1;
				s_nxt.en = 1'b0;
				if (s_r.rst_q) begin
					if (s_r.cnt >= CNT_W'(DETECT_CYC)) begin
						s_nxt.st = D_START;
						s_nxt.seen = 1'b1;
						s_nxt.long_start = nvm_write_pending;
					end else begin
						s_nxt.st = s_r.en ? D_RUN : D_START;
					end
					s_nxt.cnt = '0;
				end
			end
			default: begin
				s_nxt.st = D_START;
				s_nxt.cnt = '0;
			end
		endcase
		s_nxt.drive = s_nxt.en && sda_ack_low;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '{st: D_START, cnt: '0, rst_sy: 3'h7, scl_sy: 3'h7, sda_sy: 3'h7,
				rst_q: 1'b1, scl_q: 1'b1, sda_q: 1'b1, long_start: 1'b0, en: 1'b0,
				seen: 1'b0, drive: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.sda_dev_o  = 1'b0;
	assign link.sda_dev_oe = s_r.drive;
	assign bus_enable      = s_r.en;
	assign warm_reset_seen = s_r.seen;
	assign scl_sync        = s_r.scl_q;
	assign sda_sync        = s_r.sda_q;
endmodule : iss_dev

// ### test/iss_link_sva.sv
// Checker on the shared reset pin and serial lines
`timescale 1ns/1ps
// Defaults equal the shortened figures that the bench gives both ends, except LIM, which the bench does not set
module iss_link_sva #(
	parameter int DET = 10,
	parameter int LIM = 100,
	parameter int DSU = 50,
	parameter int HSU = 80
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rst_pin_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe
);
	logic [15:0] lo_r;
	logic [15:0] hi_r;
	// hi_r saturates so a long idle stretch never wraps back under the startup figures
	always_ff @(posedge clk) begin
		lo_r <= (!rst_n || rst_pin_n) ? 16'h0 : lo_r + 16'h1;
		hi_r <= (!rst_n || !rst_pin_n) ? 16'h0 : hi_r + {15'h0, hi_r != 16'hFFFF};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence pin_falls;
		$fell(rst_pin_n);
	endsequence
	sequence pin_rises;
		$rose(rst_pin_n);
	endsequence
	a_low_min: assert property (pin_rises |-> lo_r >= DET)
		else $error("reset pulse too short");
	a_low_max: assert property (pin_rises |-> lo_r <= LIM)
		else $error("reset pulse too long");
	a_rise_bound: assert property (pin_falls |-> ##[1:LIM] pin_rises)
		else $error("reset pin not released");
	a_lines_high: assert property (pin_falls |-> scl && sda)
		else $error("lines not high at reset");
	a_quiet_reset: assert property (!rst_pin_n |-> scl && sda && !sda_dev_oe)
		else $error("traffic during reset");
	a_dev_wait: assert property (sda_dev_oe |-> hi_r >= DSU)
		else $error("device drove early");
	a_host_wait: assert property (!scl |-> hi_r >= HSU)
		else $error("host clocked early");
	a_dev_idle: assert property (pin_rises |-> !sda_dev_oe [*8])
		else $error("device drove after release");
endmodule : iss_link_sva

// ### test/tb_i2c_startup_warm_reset_seq.sv
// Bench joining host and device ends through the shared link
`timescale 1ns/1ps
module tb_i2c_startup_warm_reset_seq;
	import iss_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, busy = 1'b0, scl_lo = 1'b0;
	logic sda_lo = 1'b0, nvm = 1'b0, ack_lo = 1'b0;
	logic rdy, ract, ben, seen, scl_s, sda_s;
	logic row_nvm [2] = '{1'b0, 1'b1};
	int   row_dev [2] = '{50, 70};
	int   mismatches = 0;
	int   checked = 0;
	int   n, m;
	iss_link_if link ();
	iss_host #(.STARTUP_CYC(80), .RESET_HOLD_CYC(20)) i_iss_host (
		.clk(clk), .rst_n(rst_n), .link(link), .warm_reset_req(req), .bus_busy(busy),
		.scl_drive_low(scl_lo), .sda_drive_low(sda_lo), .bus_ready(rdy), .reset_active(ract));
	iss_dev #(.STARTUP_CYC(50), .STARTUP_LONG_CYC(70), .DETECT_CYC(10)) i_iss_dev (
		.clk(clk), .rst_n(rst_n), .link(link), .nvm_write_pending(nvm), .sda_ack_low(ack_lo),
		.bus_enable(ben), .warm_reset_seen(seen), .scl_sync(scl_s), .sda_sync(sda_s));
	iss_link_sva i_iss_link_sva (
		.clk(clk), .rst_n(rst_n), .rst_pin_n(link.rst_pin_n), .scl(link.scl),
		.sda(link.sda), .sda_dev_oe(link.sda_dev_oe));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk_bit(string nm, logic e, logic g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic chk_rng(string nm, int lo, int hi, int g);
		checked++;
		if (g < lo || g > hi) begin
			mismatches++;
			$display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask : chk_rng
	// Counts falling edges until the level shows; a hang ends the run
	task automatic wait_for(ref logic s, input logic v, output int c);
		c = 0;
		while (s !== v && c < 2000) begin
			@(negedge clk);
			c++;
		end
		if (c >= 2000) begin
			mismatches++;
			give_verdict();
		end
	endtask : wait_for
	initial begin
		repeat (3) @(negedge clk);
		chk_bit("scl at power-up", 1'b1, link.scl);
		chk_bit("sda at power-up", 1'b1, link.sda);
		rst_n = 1'b1;
		scl_lo = 1'b1;
		ack_lo = 1'b1;
		wait_for(ben, 1'b1, n);
		chk_rng("device power-up wait", 50, 56, n);
		chk_bit("scl pull before ready", 1'b1, link.scl);
		wait_for(rdy, 1'b1, m);
		chk_rng("host power-up wait", 80, 82, n + m);
		repeat (2) @(negedge clk);
		chk_bit("scl pull when ready", 1'b0, link.scl);
		chk_bit("device answer", 1'b0, link.sda);
		req = 1'b1;
		busy = 1'b1;
		repeat (5) @(negedge clk);
		chk_bit("request while busy", 1'b1, link.rst_pin_n);
		$display("test power-up and refusal done");
		scl_lo = 1'b0;
		ack_lo = 1'b0;
		busy = 1'b0;
		// Supply stays on: only the pin restarts the device
		for (int i = 0; i < 2; i++) begin
			nvm = row_nvm[i];
			req = 1'b1;
			wait_for(link.rst_pin_n, 1'b0, n);
			req = 1'b0;
			chk_bit("reset active", 1'b1, ract);
			wait_for(link.rst_pin_n, 1'b1, n);
			chk_rng("reset low cycles", 20, 20, n);
			// User pulls during startup must stay off the lines
			scl_lo = 1'b1;
			ack_lo = 1'b1;
			wait_for(seen, 1'b1, n);
			chk_rng("reset seen delay", 3, 6, n);
			@(negedge clk);
			chk_bit("reset seen pulse", 1'b0, seen);
			chk_bit("device quiet", 1'b1, link.sda);
			wait_for(ben, 1'b1, m);
			n = n + 1 + m;
			chk_rng("device startup", row_dev[i], row_dev[i] + 6, n);
			chk_bit("host still waiting", 1'b0, rdy);
			chk_bit("device answer early", 1'b0, link.sda);
			chk_bit("scl held off", 1'b1, link.scl);
			wait_for(rdy, 1'b1, m);
			chk_rng("host startup", 80, 82, n + m);
			repeat (6) @(negedge clk);
			chk_bit("scl sync after startup", 1'b0, scl_s);
			chk_bit("sda sync after startup", 1'b0, sda_s);
			scl_lo = 1'b0;
			ack_lo = 1'b0;
			$display("test warm reset row %0d done", i);
		end
		// Mid-run reset returns both ends to their power-up state
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		chk_bit("ready in reset", 1'b0, rdy);
		chk_bit("reset flag in reset", 1'b0, ract);
		chk_bit("enable in reset", 1'b0, ben);
		chk_bit("pin in reset", 1'b1, link.rst_pin_n);
		chk_bit("scl sync in reset", 1'b1, scl_s);
		chk_bit("sda sync in reset", 1'b1, sda_s);
		rst_n = 1'b1;
		req = 1'b1;
		@(negedge clk);
		chk_bit("no seen after reset", 1'b0, seen);
		wait_for(ben, 1'b1, n);
		chk_rng("device restart wait", 50, 56, n + 1);
		chk_bit("request held off", 1'b1, link.rst_pin_n);
		req = 1'b0;
		wait_for(rdy, 1'b1, m);
		chk_rng("host restart wait", 80, 82, n + 1 + m);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule : tb_i2c_startup_warm_reset_seq
